// >>> pkg/isd_regs.svh
`ifndef ISD_REGS_SVH
`define ISD_REGS_SVH
`define ISD_LEN_SHORT 16'h0002
`define ISD_LEN_LONG  16'h0004
`define ISD_IP_RESET  16'h0000
`define ISD_SP_RESET  3'h7
`define ISD_DIV_STEPS 6'h20
`endif

// >>> pkg/isd_pkg.sv
package isd_pkg;
  typedef enum logic [4:0] {
    ISD_NOP     = 5'h00,
    ISD_MUL     = 5'h01,
    ISD_DIV     = 5'h02,
    ISD_DIVL    = 5'h03,
    ISD_CMPD    = 5'h04,
    ISD_CMPI    = 5'h05,
    ISD_NORMALISE_COUNT_OP   = 5'h06,
    ISD_BFLD    = 5'h07,
    ISD_JB      = 5'h08,
    ISD_JNB     = 5'h09,
    ISD_PUSH_AND_CALL_OP   = 5'h0A,
    ISD_CONTEXT_SWITCH_OP    = 5'h0B,
    ISD_TRAP    = 5'h0C,
    ISD_LEGACY_POWERDOWN_OP   = 5'h0D,
    ISD_SIGN_SHIFT_RIGHT_OP    = 5'h0E,
    ISD_MOVBX   = 5'h0F,
    ISD_BMOV    = 5'h10,
    ISD_RET     = 5'h11,
    ISD_COLOAD  = 5'h12,
    ISD_COSTORE = 5'h13
  } isd_op_type;
  typedef enum logic [0:0] {
    ISD_IDLE = 1'b0,
    ISD_DIVW = 1'b1
  } isd_state_type;
  typedef struct packed {
    logic        busy;
    logic        done;
    logic [5:0]  cnt;
    logic [31:0] num;
    logic [16:0] rem;
    logic        neg_q;
    logic        neg_r;
    logic [15:0] dvs;
    logic [15:0] quot;
    logic [15:0] remo;
  } isd_div_st_type;
  typedef struct packed {
    isd_state_type     state;
    logic              busy;
    logic              done;
    logic              trap;
    logic [6:0]        trap_num;
    logic [15:0]       ip;
    logic [2:0]        sp;
    logic [2:0]        psw;
    logic [31:0]       md;
    logic [31:0]       acc;
    logic [15:0][15:0] gpr;
    logic [7:0][15:0]  stk;
    logic [15:0]       rd_data;
    logic              div_start;
    logic              div_sgn;
    logic [31:0]       div_dvd;
    logic [15:0]       div_dvs;
  } isd_core_st_type;
endpackage

// >>> verilog/isd_div.sv
`include "isd_regs.svh"
module isd_div import isd_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        start_in,
  input  wire logic        signed_in,
  input  wire logic [31:0] dividend_in,
  input  wire logic [15:0] divisor_in,
  output logic             done_out,
  output logic [15:0]      quot_out,
  output logic [15:0]      rem_out
);
  isd_div_st_type q;
  isd_div_st_type d;
  logic [16:0]    trial;
  logic [31:0]    num_n;

  always_comb begin
    d = q;
    d.done = 1'b0;
    trial = {q.rem[15:0], q.num[31]};
    num_n = {q.num[30:0], 1'b0};
    if (start_in) begin
      d.neg_q = signed_in & (dividend_in[31] ^ divisor_in[15]);
      d.neg_r = signed_in & dividend_in[31];
      d.num = (signed_in & dividend_in[31]) ? -dividend_in : dividend_in;
      d.dvs = (signed_in & divisor_in[15]) ? -divisor_in : divisor_in;
      d.rem = 17'h00000;
      d.cnt = `ISD_DIV_STEPS;
      d.busy = 1'b1;
    end else if (q.busy) begin
      // Divide by zero yields an all-ones quotient, or 1 when a signed dividend is negative
      if (trial >= {1'b0, q.dvs}) begin
        trial = trial - {1'b0, q.dvs};
        num_n[0] = 1'b1;
      end
      d.num = num_n;
      d.rem = trial;
      d.cnt = q.cnt - 6'h01;
      if (q.cnt == 6'h01) begin
        d.busy = 1'b0;
        d.done = 1'b1;
        d.quot = q.neg_q ? -num_n[15:0] : num_n[15:0];
        d.remo = q.neg_r ? -trial[15:0] : trial[15:0];
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done_out = q.done;
  assign quot_out = q.quot;
  assign rem_out  = q.remo;
endmodule

// >>> verilog/isd_core.sv
`include "isd_regs.svh"
module isd_core import isd_pkg::*; (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        issue_valid_in,
  input  wire isd_op_type  op_in,
  input  wire logic        var_in,
  input  wire logic        long_in,
  input  wire logic [3:0]  dst_in,
  input  wire logic [3:0]  src_in,
  input  wire logic [15:0] imm_in,
  input  wire logic [15:0] aux_in,
  input  wire logic [3:0]  rd_idx_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [15:0]      ip_out,
  output logic [2:0]       sp_out,
  output logic [2:0]       psw_out,
  output logic [31:0]      md_out,
  output logic [31:0]      acc_out,
  output logic             trap_out,
  output logic [6:0]       trap_num_out,
  output logic [15:0]      rd_data_out
);
  isd_core_st_type q;
  isd_core_st_type d;
  logic            div_done;
  logic [15:0]     div_quot;
  logic [15:0]     div_rem;
  logic            take;
  logic [15:0]     a;
  logic [15:0]     b;
  logic [15:0]     bs;
  logic [15:0]     nxt_ip;
  logic [31:0]     prod;
  logic [7:0]      byt;
  logic            bit_v;

  function automatic logic [15:0] op_len(isd_op_type op, logic lng);
    unique case (op)
      ISD_BFLD, ISD_JB, ISD_JNB, ISD_PUSH_AND_CALL_OP, ISD_CONTEXT_SWITCH_OP, ISD_LEGACY_POWERDOWN_OP,
      ISD_BMOV, ISD_COLOAD, ISD_COSTORE: op_len = `ISD_LEN_LONG;
      ISD_CMPD, ISD_CMPI, ISD_MOVBX:
        op_len = lng ? `ISD_LEN_LONG : `ISD_LEN_SHORT;
      default: op_len = `ISD_LEN_SHORT;
    endcase
  endfunction

  // Flags are {N, Z, C}; C is the borrow of a - b
  function automatic logic [2:0] cmp_flags(logic [15:0] x, logic [15:0] y);
    logic [16:0] diff;
    diff = {1'b0, x} - {1'b0, y};
    cmp_flags = {diff[15], diff[15:0] == 16'h0000, diff[16]};
  endfunction

  // Offset counts words, so the byte target is twice it
  function automatic logic [15:0] rel_tgt(logic [15:0] ip,
                                          logic [15:0] off);
    rel_tgt = ip + {off[14:0], 1'b0};
  endfunction

  function automatic logic [15:0] normalise_count_op_cnt(logic [15:0] x);
    logic found;
    normalise_count_op_cnt = 16'h0000;
    found = 1'b0;
    // A zero word needs no shift, so it reports zero
    for (int i = 15; i >= 0; i--) begin
      if (x[i] && !found) begin
        found = 1'b1;
        normalise_count_op_cnt = 16'(15 - i);
      end
    end
  endfunction

  assign take   = issue_valid_in && (q.state == ISD_IDLE);
  assign a      = q.gpr[dst_in];
  assign bs     = q.gpr[src_in];
  assign b      = long_in ? imm_in : bs;
  assign nxt_ip = q.ip + op_len(op_in, long_in);

  always_comb begin
    d = q;
    d.done = 1'b0;
    d.trap = 1'b0;
    d.div_start = 1'b0;
    d.rd_data = q.gpr[rd_idx_in];
    prod = 32'h00000000;
    byt = 8'h00;
    bit_v = 1'b0;
    unique case (q.state)
      ISD_IDLE: begin
        if (issue_valid_in) begin
          d.ip = nxt_ip;
          d.done = 1'b1;
          unique case (op_in)
            ISD_MUL: begin
              if (var_in) begin
                prod = 32'(a) * 32'(bs);
              end else begin
                // Widen before multiplying so no tool truncates at 16 bits
                prod = 32'($signed(a)) * 32'($signed(bs));
              end
              d.md = prod;
              d.psw = {prod[31], prod == 32'h00000000, 1'b0};
            end
            ISD_DIV, ISD_DIVL: begin
              d.div_sgn = !var_in;
              d.div_dvs = bs;
              if (op_in == ISD_DIVL) begin
                d.div_dvd = q.md;
              end else begin
                d.div_dvd = {(var_in ? 16'h0000 : {16{q.md[15]}}),
                             q.md[15:0]};
              end
              d.div_start = 1'b1;
              d.busy = 1'b1;
              d.done = 1'b0;
              d.state = ISD_DIVW;
            end
            ISD_CMPD: begin
              d.psw = cmp_flags(a, b);
              d.gpr[dst_in] = a - (var_in ? 16'h0002 : 16'h0001);
            end
            ISD_CMPI: begin
              d.psw = cmp_flags(a, b);
              d.gpr[dst_in] = a + (var_in ? 16'h0002 : 16'h0001);
            end
            ISD_NORMALISE_COUNT_OP: begin
              d.gpr[dst_in] = normalise_count_op_cnt(bs);
            end
            ISD_BFLD: begin
              if (var_in) begin
                d.gpr[dst_in][15:8] = (a[15:8] & ~aux_in[7:0]) |
                                      (imm_in[7:0] & aux_in[7:0]);
              end else begin
                d.gpr[dst_in][7:0] = (a[7:0] & ~aux_in[7:0]) |
                                     (imm_in[7:0] & aux_in[7:0]);
              end
            end
            ISD_JB: begin
              bit_v = a[imm_in[3:0]];
              if (bit_v) begin
                d.ip = rel_tgt(nxt_ip, aux_in);
                if (var_in) begin
                  d.gpr[dst_in][imm_in[3:0]] = 1'b0;
                end
              end
            end
            ISD_JNB: begin
              bit_v = a[imm_in[3:0]];
              if (!bit_v) begin
                d.ip = rel_tgt(nxt_ip, aux_in);
                if (var_in) begin
                  d.gpr[dst_in][imm_in[3:0]] = 1'b1;
                end
              end
            end
            ISD_PUSH_AND_CALL_OP: begin
              d.stk[q.sp] = a;
              d.stk[q.sp - 3'h1] = nxt_ip;
              d.sp = q.sp - 3'h2;
              d.ip = imm_in;
            end
            ISD_CONTEXT_SWITCH_OP: begin
              d.stk[q.sp] = a;
              d.sp = q.sp - 3'h1;
              d.gpr[dst_in] = b;
            end
            ISD_TRAP: begin
              d.stk[q.sp] = nxt_ip;
              d.sp = q.sp - 3'h1;
              d.ip = {7'h00, imm_in[6:0], 2'h0};
              d.trap = 1'b1;
              d.trap_num = imm_in[6:0];
            end
            ISD_LEGACY_POWERDOWN_OP: begin
              // Kept decodable so old code images still run through it
              d.ip = nxt_ip;
            end
            ISD_SIGN_SHIFT_RIGHT_OP: begin
              d.gpr[dst_in] = 16'($signed(a) >>> imm_in[3:0]);
            end
            ISD_MOVBX: begin
              byt = long_in ? imm_in[7:0] : bs[7:0];
              d.gpr[dst_in] = {(var_in ? 8'h00 : {8{byt[7]}}),
                               byt};
            end
            ISD_BMOV: begin
              bit_v = bs[imm_in[7:4]] ^ var_in;
              d.gpr[dst_in][imm_in[3:0]] = bit_v;
            end
            ISD_RET: begin
              d.ip = q.stk[q.sp + 3'h1];
              d.sp = q.sp + 3'h1;
              if (var_in) begin
                d.gpr[dst_in] = q.stk[q.sp + 3'h2];
                d.sp = q.sp + 3'h2;
              end
            end
            ISD_COLOAD: begin
              d.acc = {a, bs};
            end
            ISD_COSTORE: begin
              d.gpr[dst_in] = src_in[0] ? q.acc[31:16]
                                        : q.acc[15:0];
            end
            ISD_NOP: begin
              d.ip = nxt_ip;
            end
            default: begin
              d.ip = nxt_ip;
            end
          endcase
        end
      end
      ISD_DIVW: begin
        if (div_done) begin
          d.md = {div_rem, div_quot};
          d.psw = {div_quot[15], div_quot == 16'h0000, 1'b0};
          d.busy = 1'b0;
          d.done = 1'b1;
          d.state = ISD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= '0;
      q.ip <= `ISD_IP_RESET;
      q.sp <= `ISD_SP_RESET;
    end else begin
      q <= d;
    end
  end

  isd_div u_div (
    .clk_in      (clk_in),
    .nrst_in     (nrst_in),
    .start_in    (q.div_start),
    .signed_in   (q.div_sgn),
    .dividend_in (q.div_dvd),
    .divisor_in  (q.div_dvs),
    .done_out    (div_done),
    .quot_out    (div_quot),
    .rem_out     (div_rem)
  );

  assign busy_out     = q.busy;
  assign done_out     = q.done;
  assign ip_out       = q.ip;
  assign sp_out       = q.sp;
  assign psw_out      = q.psw;
  assign md_out       = q.md;
  assign acc_out      = q.acc;
  assign trap_out     = q.trap;
  assign trap_num_out = q.trap_num;
  assign rd_data_out  = q.rd_data;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  property p_mul;
    take && op_in == ISD_MUL && var_in |=>
      md_out == $past(32'(a) * 32'(bs));
  endproperty
  a_mul: assert property (p_mul)
    else $error("unsigned product wrong");

  property p_div_time;
    take && op_in == ISD_DIV |-> ##[2:40] done_out;
  endproperty
  a_div_time: assert property (p_div_time)
    else $error("short divide did not finish");

  property p_divl;
    done_out && !q.div_sgn && q.div_dvs != 16'h0000 &&
      q.div_dvd[31:16] < q.div_dvs && $past(q.state) == ISD_DIVW |->
      32'(md_out[15:0]) * 32'(q.div_dvs) + 32'(md_out[31:16])
        == q.div_dvd;
  endproperty
  a_divl: assert property (p_divl)
    else $error("divide result inconsistent");

  property p_cmpd;
    take && op_in == ISD_CMPD |=> q.gpr[$past(dst_in)] ==
      $past(a) - ($past(var_in) ? 16'h0002 : 16'h0001);
  endproperty
  a_cmpd: assert property (p_cmpd)
    else $error("compare-decrement step wrong");

  property p_cmpi;
    take && op_in == ISD_CMPI |=> q.gpr[$past(dst_in)] ==
      $past(a) + ($past(var_in) ? 16'h0002 : 16'h0001);
  endproperty
  a_cmpi: assert property (p_cmpi)
    else $error("compare-increment step wrong");

  property p_context_switch_op;
    take && op_in == ISD_CONTEXT_SWITCH_OP |=> sp_out == $past(sp_out) - 3'h1 &&
      q.gpr[$past(dst_in)] == $past(b) && q.stk[$past(sp_out)] == $past(a);
  endproperty
  a_context_switch_op: assert property (p_context_switch_op)
    else $error("context switch wrong");

  property p_trap;
    take && op_in == ISD_TRAP |=> trap_out &&
      ip_out == {7'h00, $past(imm_in[6:0]), 2'h0} ##1 !trap_out;
  endproperty
  a_trap: assert property (p_trap)
    else $error("trap vector or pulse wrong");

  property p_legacy_powerdown_op;
    take && op_in == ISD_LEGACY_POWERDOWN_OP |=> ip_out == $past(ip_out) + `ISD_LEN_LONG
      && sp_out == $past(sp_out) && q.gpr == $past(q.gpr) && $stable(md_out);
  endproperty
  a_legacy_powerdown_op: assert property (p_legacy_powerdown_op)
    else $error("power-down opcode had an effect");

  property p_sign_shift_right_op;
    take && op_in == ISD_SIGN_SHIFT_RIGHT_OP |=> q.gpr[$past(dst_in)] ==
      16'($signed($past(a)) >>> $past(imm_in[3:0]));
  endproperty
  a_sign_shift_right_op: assert property (p_sign_shift_right_op)
    else $error("arithmetic shift wrong");

  property p_len;
    take && op_in == ISD_MOVBX |=> ip_out == $past(ip_out) +
      ($past(long_in) ? `ISD_LEN_LONG : `ISD_LEN_SHORT);
  endproperty
  a_len: assert property (p_len)
    else $error("pointer advance wrong");
endmodule

// >>> dv/tb.sv
module tb import isd_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic [15:0] ip;
    logic [2:0]  sp;
    logic [31:0] md;
    logic [31:0] acc;
    logic        tr;
    logic [6:0]  tn;
    logic [15:0] gv;
  } isd_note_type;

  logic        clk_in;
  logic        nrst_in;
  logic        issue_valid_in;
  isd_op_type  op_in;
  logic        var_in;
  logic        long_in;
  logic [3:0]  dst_in;
  logic [3:0]  src_in;
  logic [15:0] imm_in;
  logic [15:0] aux_in;
  logic [3:0]  rd_idx_in;
  logic        busy_out;
  logic        done_out;
  logic [15:0] ip_out;
  logic [2:0]  sp_out;
  logic [2:0]  psw_out;
  logic [31:0] md_out;
  logic [31:0] acc_out;
  logic        trap_out;
  logic [6:0]  trap_num_out;
  logic [15:0] rd_data_out;

  // Reference model of the architectural state
  logic [15:0]  g [16];
  logic [15:0]  eip;
  logic [2:0]   esp;
  logic [31:0]  emd;
  logic [31:0]  eacc;
  logic         etr;
  logic [6:0]   etn;
  isd_note_type q [$];
  logic [15:0]  pg;
  logic         pend;
  int           num_errors;
  int           samples_checked;
  int           cyc;

  isd_core i_dut (
    .clk_in, .nrst_in, .issue_valid_in, .op_in, .var_in, .long_in,
    .dst_in, .src_in, .imm_in, .aux_in, .rd_idx_in, .busy_out, .done_out,
    .ip_out, .sp_out, .psw_out, .md_out, .acc_out, .trap_out,
    .trap_num_out, .rd_data_out
  );

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(string s, logic [31:0] e, logic [31:0] v);
    samples_checked++;
    if (v !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, v);
    end
  endtask

  function automatic logic [15:0] pri(logic [15:0] x);
    logic [15:0] c;
    c = 16'h0000;
    if (x != 16'h0000) begin
      while (!x[15]) begin
        x = x << 1;
        c++;
      end
    end
    return c;
  endfunction

  // Caller updates the model first; the note snapshots it
  task automatic go(isd_op_type o, logic v, logic l, logic [3:0] d,
                    logic [3:0] s, logic [15:0] i, logic [15:0] a);
    int n;
    q.push_back('{eip, esp, emd, eacc, etr, etn, g[d]});
    op_in = o;
    var_in = v;
    long_in = l;
    dst_in = d;
    src_in = s;
    imm_in = i;
    aux_in = a;
    rd_idx_in = d;
    issue_valid_in = 1'b1;
    @(negedge clk_in);
    issue_valid_in = 1'b0;
    n = 0;
    if (o == ISD_DIVL) begin
      chk("busy", 1, busy_out);
      // A request while busy must leave no trace
      op_in = ISD_LEGACY_POWERDOWN_OP;
      issue_valid_in = 1'b1;
      repeat (3) @(negedge clk_in);
      issue_valid_in = 1'b0;
      op_in = o;
      n = 3;
    end
    while (done_out !== 1'b1 && n < 60) begin
      @(negedge clk_in);
      n++;
    end
    if (n == 60) begin
      num_errors++;
      $display("[FAIL] done expected 1 seen 0");
    end
    repeat (2) @(negedge clk_in);
    etr = 1'b0;
  endtask

  task automatic ld(logic [3:0] k, logic [15:0] val);
    esp -= 3'h1;
    eip += 16'h0004;
    g[k] = val;
    go(ISD_CONTEXT_SWITCH_OP, 1'b0, 1'b1, k, k, val, 16'h0000);
  endtask

  always @(negedge clk_in) begin
    isd_note_type n;
    if (pend) begin
      chk("gpr", pg, rd_data_out);
      pend = 1'b0;
    end
    if (done_out === 1'b1) begin
      if (q.size() == 0) begin
        num_errors++;
        $display("[FAIL] done expected 0 seen 1");
      end else begin
        n = q.pop_front();
        chk("ip", n.ip, ip_out);
        chk("sp", n.sp, sp_out);
        chk("md", n.md, md_out);
        chk("acc", n.acc, acc_out);
        chk("trap", n.tr, trap_out);
        if (n.tr) chk("trap_num", n.tn, trap_num_out);
        pg = n.gv;
        pend = 1'b1;
      end
    end
  end

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("[FAIL] run expected end seen hang");
      finish_test();
    end
  end

  initial begin
    logic [15:0] r, b, qq, rr;
    logic [31:0] t, u;
    issue_valid_in = 1'b0;
    op_in = ISD_NOP;
    var_in = 1'b0;
    long_in = 1'b0;
    dst_in = 4'h0;
    src_in = 4'h0;
    imm_in = 16'h0000;
    aux_in = 16'h0000;
    rd_idx_in = 4'h0;
    nrst_in = 1'b0;
    pend = 1'b0;
    foreach (g[k]) g[k] = 16'h0000;
    eip = 16'h0000;
    esp = 3'h7;
    emd = 32'h0000_0000;
    eacc = 32'h0000_0000;
    etr = 1'b0;
    etn = 7'h00;
    void'($urandom(32'h16A2));
    repeat (12) @(negedge clk_in);
    nrst_in = 1'b1;
    @(negedge clk_in);
    chk("ip", 0, ip_out);
    chk("sp", 7, sp_out);
    chk("md", 0, md_out);
    for (int k = 0; k < 16; k++) begin
      r = $urandom;
      ld(k[3:0], r);
    end
    $display("test load done");
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      ld(4'h1, r);
      r = $urandom;
      ld(4'h2, r);
      if (k[0]) emd = g[1] * g[2];
      else emd = $signed(g[1]) * $signed(g[2]);
      eip += 16'h0002;
      go(ISD_MUL, k[0], 1'b0, 4'h1, 4'h2, 16'h0000, 16'h0000);
      chk("psw", {29'h0, emd[31], emd == 32'h0, 1'b0}, psw_out);
    end
    $display("test multiply done");
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      ld(4'h3, r | 16'h0001);
      b = g[3];
      if (k[1]) begin
        if (k[0]) begin
          t = emd / {16'h0000, b};
          u = emd % {16'h0000, b};
        end else begin
          t = $signed(emd) / $signed({{16{b[15]}}, b});
          u = $signed(emd) % $signed({{16{b[15]}}, b});
        end
        emd = {u[15:0], t[15:0]};
      end else begin
        if (k[0]) begin
          qq = emd[15:0] / b;
          rr = emd[15:0] % b;
        end else begin
          qq = $signed(emd[15:0]) / $signed(b);
          rr = $signed(emd[15:0]) % $signed(b);
        end
        emd = {rr, qq};
      end
      eip += 16'h0002;
      go(k[1] ? ISD_DIVL : ISD_DIV, k[0], 1'b0, 4'h3, 4'h3, 0, 0);
      chk("psw", {29'h0, emd[15], emd[15:0] == 16'h0, 1'b0}, psw_out);
    end
    $display("test divide done");
    for (int k = 0; k < 8; k++) begin
      r = $urandom;
      b = k[1] ? 16'h0002 : 16'h0001;
      qq = k[0] ? r : g[5];
      // Flags are {N, Z, borrow} of the old register minus the operand
      t = {16'h0000, g[4]} - {16'h0000, qq};
      g[4] = k[2] ? g[4] + b : g[4] - b;
      eip += k[0] ? 16'h0004 : 16'h0002;
      go(k[2] ? ISD_CMPI : ISD_CMPD, k[1], k[0], 4'h4, 4'h5, r, 0);
      chk("psw", {29'h0, t[15], t[15:0] == 16'h0, t[16]}, psw_out);
    end
    $display("test compare done");
    for (int k = 0; k < 2; k++) begin
      r = $urandom;
      r = k ? r >> r[3:0] : 16'h0000;
      ld(4'h6, r);
      g[5] = pri(r);
      eip += 16'h0002;
      go(ISD_NORMALISE_COUNT_OP, 1'b0, 1'b0, 4'h5, 4'h6, 0, 0);
      r = $urandom;
      ld(4'h7, k ? r | 16'h8000 : r & 16'h7FFF);
      r = $urandom;
      g[7] = $signed(g[7]) >>> r[3:0];
      eip += 16'h0002;
      go(ISD_SIGN_SHIFT_RIGHT_OP, 1'b0, 1'b0, 4'h7, 4'h7, r, 0);
    end
    $display("test normalise and shift done");
    for (int k = 0; k < 4; k++) begin
      r = $urandom;
      ld(4'h8, r);
      r = $urandom;
      if (!k[1]) r = g[8];
      g[8] = k[0] ? {8'h00, r[7:0]} : {{8{r[7]}}, r[7:0]};
      eip += k[1] ? 16'h0004 : 16'h0002;
      go(ISD_MOVBX, k[0], k[1], 4'h8, 4'h8, r, 0);
      r = $urandom;
      b = $urandom;
      t[15:0] = k[0] ? {b[7:0], 8'h00} : {8'h00, b[7:0]};
      u[15:0] = k[0] ? {r[7:0], 8'h00} : {8'h00, r[7:0]};
      g[10] = (g[10] & ~t[15:0]) | (u[15:0] & t[15:0]);
      eip += 16'h0004;
      go(ISD_BFLD, k[0], 1'b0, 4'hA, 4'hA, r, b);
      g[11][r[3:0]] = g[12][r[7:4]] ^ k[0];
      eip += 16'h0004;
      go(ISD_BMOV, k[0], 1'b0, 4'hB, 4'hC, r, 0);
    end
    $display("test byte and bit moves done");
    for (int k = 0; k < 8; k++) begin
      r = $urandom;
      b = $urandom & 16'h7FFF;
      qq = $urandom;
      qq[r[3:0]] = k[1];
      ld(4'hD, qq);
      if (k[2] ^ k[1]) begin
        eip = eip + 16'h0004 + {b[14:0], 1'b0};
        if (k[0]) g[13][r[3:0]] = ~k[1];
      end else begin
        eip += 16'h0004;
      end
      go(k[2] ? ISD_JNB : ISD_JB, k[0], 1'b0, 4'hD, 4'hD,
         {8'h00, r[3:0], r[3:0]}, b);
    end
    $display("test bit jumps done");
    r = $urandom & 16'hFFFE;
    b = eip + 16'h0004;
    qq = g[14];
    esp -= 3'h2;
    eip = r;
    go(ISD_PUSH_AND_CALL_OP, 1'b0, 1'b0, 4'hE, 4'hE, r, 0);
    r = $urandom;
    g[14] = {8'h00, r[7:0]};
    eip += 16'h0004;
    go(ISD_MOVBX, 1'b1, 1'b1, 4'hE, 4'hE, r, 0);
    g[14] = qq;
    esp += 3'h2;
    eip = b;
    go(ISD_RET, 1'b1, 1'b0, 4'hE, 4'hE, 0, 0);
    r = $urandom;
    b = eip + 16'h0002;
    esp -= 3'h1;
    eip = {7'h00, r[6:0], 2'h0};
    etr = 1'b1;
    etn = r[6:0];
    go(ISD_TRAP, 1'b0, 1'b0, 4'h0, 4'h0, {9'h000, r[6:0]}, 0);
    esp += 3'h1;
    eip = b;
    go(ISD_RET, 1'b0, 1'b0, 4'h0, 4'h0, 0, 0);
    $display("test call trap return done");
    eip += 16'h0004;
    go(ISD_LEGACY_POWERDOWN_OP, 1'b0, 1'b0, 4'h9, 4'h9, 16'hFFFF, 16'hFFFF);
    eacc = {g[1], g[2]};
    eip += 16'h0004;
    go(ISD_COLOAD, 1'b0, 1'b0, 4'h1, 4'h2, 0, 0);
    for (int k = 0; k < 2; k++) begin
      g[15] = k ? eacc[31:16] : eacc[15:0];
      eip += 16'h0004;
      go(ISD_COSTORE, 1'b0, 1'b0, 4'hF, {3'h0, k[0]}, 0, 0);
    end
    $display("test power-down and mac done");
    finish_test();
  end
endmodule
